//--- common/rias_hold_if.sv
// Purpose: carries the alarm reset level to the hold timer and back
// Assumes: both ends on CLOCK
// Notes: done is a one-cycle pulse per qualifying hold
interface rias_hold_if;
  logic level; // reset input held on
  logic done;  // hold reached the least time

  // user end drives the level, reads the pulse
  modport user (output level, input done);
  // timer end measures the level
  modport timer (input level, output done);
endinterface

//--- common/rias_pkg.sv
// Purpose: shared constants for the remote input, alarm and stop block
// Assumes: one 25 MHz system clock
// Notes: times are kept in their own unit, cycle counts derived here
package rias_pkg;

  // system clock rate in hertz
  localparam int unsigned CLK_HZ = 25_000_000;
  // least hold time of the alarm reset input, in milliseconds
  localparam int unsigned RESET_HOLD_MS = 50;
  // least hold time in cycles, never less than one
  localparam int unsigned RESET_HOLD_CYC =
    (RESET_HOLD_MS * (CLK_HZ / 1000) + 0) < 1 ? 1 :
    RESET_HOLD_MS * (CLK_HZ / 1000);

  // default number of output devices routed out
  localparam int unsigned OUT_DEV_NUM = 8;
  // default mask of output devices barred from the fieldbus
  localparam logic [7:0] OUT_FB_BAR_DEF = 8'h00;

  // digit of the function select word that asks for shut-off
  localparam int unsigned D1_DIGIT_LSB = 4;
  localparam int unsigned D1_DIGIT_W = 4;
  // digit value that requests base shut-off on reset input
  localparam logic [3:0] D1_SHUTOFF_VAL = 4'h1;

  // forced stop state, one-hot
  typedef enum logic [1:0] {
    RIAS_FS_RUN = 2'b01,
    RIAS_FS_STOP = 2'b10
  } rias_fs_t;

  // alarm state, one-hot
  typedef enum logic [1:0] {
    RIAS_AL_CLEAR = 2'b01,
    RIAS_AL_ACTIVE = 2'b10
  } rias_al_t;

endpackage

//--- sim/rias_master_model.sv
// Purpose: fieldbus master side that holds the alarm reset bits
// Assumes: driven from tb on CLOCK rising edges
// Notes: one request holds one station bit for len cycles
module rias_master_model
  import rias_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // request from the bench
  input wire logic start,
  input wire logic sel,
  input wire logic [15:0] len,
  input wire logic moving,
  // reset bits toward the device
  output logic reset_one,
  output logic reset_two,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_q; // cycles of hold left
  logic sel_q; // station chosen for this hold

  // count the hold down; no request taken during motion
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q <= 16'h0000;
      sel_q <= 1'b0;
    end
    else if (start && !moving)
    begin
      cnt_q <= len;
      sel_q <= sel;
    end
    else if (cnt_q != 16'h0000)
      cnt_q <= cnt_q - 16'h0001;
  end

  // bit stays on without a gap for the whole hold
  assign busy = (cnt_q != 16'h0000);
  assign reset_one = busy && !sel_q;
  assign reset_two = busy && sel_q;
endmodule

//--- sim/tb_top.sv
// Purpose: self-checking bench for the remote input and stop block
// Assumes: hold time shortened to 8 cycles, two outputs barred
// Notes: inputs change by non-blocking assignment at rising edges
module tb_top
  import rias_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned HOLD = 8; // shortened hold time
  localparam logic [7:0] BAR = 8'h81; // outputs kept off the fieldbus
  logic CLOCK = 1'b0;
  logic RESETN, ABS_INC, SPEC, CMD_ABS, FS_IN, RAISE, FIXED;
  logic [15:0] D1;
  logic [7:0] OUT_DEV, FB, LOCAL;
  logic PT, REG, POS, AL, BASE, BRAKE, FS, R1, R2;
  logic h_start, h_sel, h_busy, h_moving;
  logic [15:0] h_len;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  // packed view of the status outputs
  wire logic [7:0] stat = {1'b0, PT, REG, POS, AL, BASE, BRAKE, FS};

  // clock source
  always #20 CLOCK = ~CLOCK;

  rias_top #(.HOLD_CYCLES(HOLD), .N_OUT(8), .FB_BAR(BAR)) u_rias_top (
    .CLOCK(CLOCK), .RESETN(RESETN), .ABS_INC_SELECT_BIT(ABS_INC),
    .SPEC_SYSTEM_SELECT_BIT(SPEC), .ALARM_RESET_BIT_ONE_STATION(R1),
    .ALARM_RESET_BIT_TWO_STATION(R2), .COMMAND_SYSTEM_PARAM_ABS(CMD_ABS),
    .FUNCTION_SELECT_D1_PARAM(D1), .FORCED_STOP_INPUT(FS_IN),
    .ALARM_RAISE(RAISE), .ALARM_RAISE_FIXED(FIXED), .OUT_DEVICES(OUT_DEV),
    .POINT_TABLE_MODE(PT), .REGISTER_CMD_MODE(REG), .POS_INCREMENTAL(POS),
    .ALARM_ACTIVE(AL), .BASE_ENABLE(BASE), .DYN_BRAKE(BRAKE),
    .FORCED_STOP_STATE(FS), .FIELDBUS_OUT(FB), .LOCAL_IO_CONNECTOR_OUT(LOCAL));

  rias_master_model u_rias_master_model (
    .clock(CLOCK), .resetn(RESETN), .start(h_start), .sel(h_sel),
    .len(h_len), .moving(h_moving), .reset_one(R1), .reset_two(R2),
    .busy(h_busy));

  // byte compare
  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // single bit compare
  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask

  // let an input change pass through the registers
  task automatic settle();
    repeat (2) @(posedge CLOCK);
    #1;
  endtask

  task automatic done(input string nm);
    $display("test %s finished, mismatches so far %0d", nm, fails);
  endtask

  // ask the master model for one hold of the reset bit
  task automatic hold_start(input int len, input logic sel);
    @(posedge CLOCK);
    h_start <= 1'b1;
    h_len <= 16'(len);
    h_sel <= sel;
    @(posedge CLOCK);
    h_start <= 1'b0;
  endtask

  // wait for the hold to end, bounded, then for the outputs
  task automatic hold_wait();
    int i;
    #1;
    i = 0;
    while (h_busy === 1'b1 && i < 40)
    begin
      @(posedge CLOCK);
      #1;
      i++;
    end
    chk1("hold busy", 1'b0, h_busy);
    repeat (3) @(posedge CLOCK);
    #1;
  endtask

  // one cycle alarm event
  task automatic alarm(input logic fixed_al);
    @(posedge CLOCK);
    RAISE <= 1'b1;
    FIXED <= fixed_al;
    @(posedge CLOCK);
    RAISE <= 1'b0;
    FIXED <= 1'b0;
    settle();
  endtask

  // reset pulse with checks of reset and run values
  task automatic do_reset();
    @(posedge CLOCK);
    RESETN <= 1'b0;
    repeat (10) @(posedge CLOCK);
    #1;
    chk8("status in reset", 8'h43, stat);
    chk8("fieldbus in reset", 8'h00, FB);
    @(posedge CLOCK);
    RESETN <= 1'b1;
    settle();
    chk8("status after reset", 8'h44, stat);
  endtask

  // closing report
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard
  always @(posedge CLOCK)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails++;
      $display("[ERR] cycle limit expected 3000 seen %0d", cyc);
      finish_test();
    end
  end

  // main sequence
  initial
  begin
    RESETN <= 1'b0;
    {ABS_INC, SPEC, CMD_ABS, RAISE, FIXED, h_start, h_sel} <= 7'h00;
    h_moving <= 1'b0;
    FS_IN <= 1'b1;
    D1 <= 16'h0000;
    OUT_DEV <= 8'h00;
    h_len <= 16'h0000;
    do_reset();
    done("reset");
    // every select combination
    for (int i = 0; i < 8; i++)
    begin
      @(posedge CLOCK);
      {SPEC, CMD_ABS, ABS_INC} <= 3'(i);
      settle();
      chk1("incremental", i == 7, POS);
      chk1("point table", !i[2], PT);
      chk1("register cmd", i[2], REG);
      chk1("fieldbus stop", 1'b0, FS);
    end
    @(posedge CLOCK);
    {SPEC, CMD_ABS, ABS_INC} <= 3'h0;
    done("select");
    // forced stop from the local input and back
    @(posedge CLOCK);
    FS_IN <= 1'b0;
    settle();
    chk8("stopped status", 8'h43, stat);
    @(posedge CLOCK);
    FS_IN <= 1'b1;
    settle();
    chk8("resumed status", 8'h44, stat);
    done("forced stop");
    // alarm, too short a hold, then a full hold
    alarm(1'b0);
    chk8("alarm status", 8'h4a, stat);
    hold_start(HOLD - 1, 1'b0);
    hold_wait();
    chk8("short hold", 8'h4a, stat);
    hold_start(HOLD, 1'b1);
    hold_wait();
    chk8("full hold", 8'h44, stat);
    // alarm of a class that survives the reset input
    alarm(1'b1);
    hold_start(HOLD + 4, 1'b0);
    hold_wait();
    chk8("fixed alarm", 8'h4a, stat);
    do_reset();
    done("alarm");
    // reset input with no alarm, shut-off digit off and on
    for (int k = 0; k < 2; k++)
    begin
      @(posedge CLOCK);
      D1 <= k ? 16'h0010 : 16'h0000;
      hold_start(HOLD + 4, k[0]);
      repeat (4) @(posedge CLOCK);
      #1;
      chk1("base while held", k == 0, BASE);
      hold_wait();
      chk1("base after hold", 1'b1, BASE);
    end
    done("base");
    // output devices on both routes
    for (int v = 0; v < 3; v++)
    begin
      @(posedge CLOCK);
      OUT_DEV <= 8'h5a ^ 8'(v * 8'h3c);
      settle();
      chk8("fieldbus out", (8'h5a ^ 8'(v * 8'h3c)) & ~BAR, FB);
      chk8("local out", 8'h5a ^ 8'(v * 8'h3c), LOCAL);
    end
    done("outputs");
    // master keeps the reset bits off while the axis moves
    @(posedge CLOCK);
    h_moving <= 1'b1;
    hold_start(HOLD, 1'b0);
    #1;
    chk1("no reset in motion", 1'b0, h_busy);
    @(posedge CLOCK);
    h_moving <= 1'b0;
    done("motion");
    finish_test();
  end
endmodule

//--- src/rias_hold_timer.sv
// Purpose: measures how long the alarm reset input stays on
// Assumes: level is synchronous to clock
// Notes: any drop of the level restarts the measurement
module rias_hold_timer
  import rias_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = RESET_HOLD_CYC
)
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // level in, pulse out
  rias_hold_if.timer hold
);

  localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(HOLD_CYCLES - 1);
  localparam logic [CW-1:0] CNT_ZERO = '0;
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  // refuse a hold too short to be measured
  if (HOLD_CYCLES < 2)
  begin : g_chk
    $error("hold count must be at least two cycles");
  end

  logic [CW-1:0] cnt_q; // cycles the level has stood
  logic [CW-1:0] cnt_d;
  logic fired_q; // pulse already given for this hold
  logic fired_d;

  // next count; short holds never reach the end
  always_comb
  begin
    cnt_d = cnt_q;
    fired_d = fired_q;
    if (!hold.level)
    begin
      cnt_d = CNT_ZERO;
      fired_d = 1'b0;
    end
    else if (cnt_q != CNT_LAST)
    begin
      cnt_d = cnt_q + CNT_ONE;
    end
    else
    begin
      fired_d = 1'b1;
    end
  end

  // register the count
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q <= CNT_ZERO;
      fired_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      fired_q <= fired_d;
    end
  end

  // one pulse once the level has stood the full time
  assign hold.done = hold.level && (cnt_q == CNT_LAST) && !fired_q;

  // pulse only after the level stood the previous cycle too
  hold_needs_level_a: assert property (
    @(posedge clock) disable iff (!resetn)
    hold.done |-> $past(hold.level) && hold.level)
    else $error("hold pulse without a held level");

endmodule

//--- src/rias_out_route.sv
// Purpose: copies output devices to the fieldbus and the local connector
// Assumes: device states are synchronous to clock
// Notes: barred devices read as zero on the fieldbus
module rias_out_route
  import rias_pkg::*;
#(
  parameter int unsigned N = OUT_DEV_NUM,
  parameter logic [N-1:0] FB_BAR = N'(OUT_FB_BAR_DEF)
)
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // device states in
  input wire logic [N-1:0] dev,
  // routed copies
  output logic [N-1:0] fb_out,
  output logic [N-1:0] local_out
);

  // refuse an empty device group
  if (N < 1)
  begin : g_chk
    $error("at least one output device is needed");
  end

  logic [N-1:0] fb_d;
  logic [N-1:0] local_d;

  // both copies, fieldbus masked
  always_comb
  begin
    local_d = dev;
    fb_d = dev & ~FB_BAR;
  end

  // register the copies
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      fb_out <= '0;
      local_out <= '0;
    end
    else
    begin
      fb_out <= fb_d;
      local_out <= local_d;
    end
  end

  // both copies follow the device one cycle later
  route_copy_a: assert property (
    @(posedge clock) disable iff (!resetn)
    ##1 (local_out == $past(dev)) && (fb_out == ($past(dev) & ~FB_BAR)))
    else $error("output device copies wrong");

endmodule

//--- src/rias_top.sv
// Purpose: remote input handling for position select, alarm reset, stop
// Assumes: all inputs synchronous to CLOCK; parameters held steady
// Notes: forced stop comes only from the local connector
//
// Contract
// - select bit only valid in register absolute mode
// - bit off absolute, bit on incremental
// - reset held 50ms clears resettable alarm
// - some alarm classes survive the reset input
// - reset without alarm keeps base circuit on
// - function select digit one forces base shut-off
// - forced stop only from local connector
// - forced stop off: base off, brake on
// - forced stop on again leaves stop state
// - outputs on fieldbus and connector, unless barred
// - spec bit picks point table or register
module rias_top
  import rias_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = RESET_HOLD_CYC,
  parameter int unsigned N_OUT = OUT_DEV_NUM,
  parameter logic [N_OUT-1:0] FB_BAR = N_OUT'(OUT_FB_BAR_DEF)
)
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // fieldbus remote input bits
  input wire logic ABS_INC_SELECT_BIT,
  input wire logic SPEC_SYSTEM_SELECT_BIT,
  input wire logic ALARM_RESET_BIT_ONE_STATION,
  input wire logic ALARM_RESET_BIT_TWO_STATION,
  // parameter settings
  input wire logic COMMAND_SYSTEM_PARAM_ABS,
  input wire logic [15:0] FUNCTION_SELECT_D1_PARAM,
  // local connector input, high means run
  input wire logic FORCED_STOP_INPUT,
  // alarm sources from the servo core
  input wire logic ALARM_RAISE,
  input wire logic ALARM_RAISE_FIXED,
  // output devices from the servo core
  input wire logic [N_OUT-1:0] OUT_DEVICES,
  // command selection results
  output logic POINT_TABLE_MODE,
  output logic REGISTER_CMD_MODE,
  output logic POS_INCREMENTAL,
  // alarm and power stage
  output logic ALARM_ACTIVE,
  output logic BASE_ENABLE,
  output logic DYN_BRAKE,
  output logic FORCED_STOP_STATE,
  // routed output devices
  output logic [N_OUT-1:0] FIELDBUS_OUT,
  output logic [N_OUT-1:0] LOCAL_IO_CONNECTOR_OUT
);

  // refuse a hold too short to be measured
  if (HOLD_CYCLES < 2)
  begin : g_chk
    $error("hold count must be at least two cycles");
  end

  // link to the hold timer
  rias_hold_if hold ();

  // either station's reset bit counts
  logic reset_lvl;
  assign reset_lvl = ALARM_RESET_BIT_ONE_STATION ||
    ALARM_RESET_BIT_TWO_STATION;
  assign hold.level = reset_lvl;

  // function select asks for shut-off on reset
  logic d1_shutoff;
  assign d1_shutoff =
    FUNCTION_SELECT_D1_PARAM[D1_DIGIT_LSB +: D1_DIGIT_W] == D1_SHUTOFF_VAL;

  // measures the reset hold
  rias_hold_timer #(
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_hold (
    .clock(CLOCK),
    .resetn(RESETN),
    .hold(hold)
  );

  // routes output devices to both sides
  rias_out_route #(
    .N(N_OUT),
    .FB_BAR(FB_BAR)
  ) u_route (
    .clock(CLOCK),
    .resetn(RESETN),
    .dev(OUT_DEVICES),
    .fb_out(FIELDBUS_OUT),
    .local_out(LOCAL_IO_CONNECTOR_OUT)
  );

  // command selection state
  logic pt_d;
  logic reg_d;
  logic inc_d;

  // command selection next values
  always_comb
  begin
    reg_d = SPEC_SYSTEM_SELECT_BIT;
    pt_d = !SPEC_SYSTEM_SELECT_BIT;
    // honoured only in register mode with absolute command system
    if (SPEC_SYSTEM_SELECT_BIT && COMMAND_SYSTEM_PARAM_ABS)
    begin
      inc_d = ABS_INC_SELECT_BIT;
    end
    else
    begin
      inc_d = 1'b0;
    end
  end

  // register command selection
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      POINT_TABLE_MODE <= 1'b1;
      REGISTER_CMD_MODE <= 1'b0;
      POS_INCREMENTAL <= 1'b0;
    end
    else
    begin
      POINT_TABLE_MODE <= pt_d;
      REGISTER_CMD_MODE <= reg_d;
      POS_INCREMENTAL <= inc_d;
    end
  end

  // alarm state
  rias_al_t al_q; // alarm present
  rias_al_t al_d;
  logic fixed_q; // present alarm not clearable by reset
  logic fixed_d;

  // alarm next state; a new alarm wins over a clear
  always_comb
  begin
    al_d = al_q;
    fixed_d = fixed_q;
    case (al_q)
      RIAS_AL_CLEAR:
      begin
        if (ALARM_RAISE)
        begin
          al_d = RIAS_AL_ACTIVE;
          fixed_d = ALARM_RAISE_FIXED;
        end
      end
      RIAS_AL_ACTIVE:
      begin
        if (ALARM_RAISE)
        begin
          fixed_d = fixed_q || ALARM_RAISE_FIXED; // set wins
        end
        else if (hold.done && !fixed_q)
        begin
          al_d = RIAS_AL_CLEAR;
          fixed_d = 1'b0;
        end
        // fixed alarms ignore the reset hold
        else if (hold.done)
        begin
          al_d = RIAS_AL_ACTIVE;
        end
      end
      default:
      begin
        al_d = RIAS_AL_ACTIVE; // illegal code: fail safe
        fixed_d = 1'b1;
      end
    endcase
  end

  // register alarm state
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      al_q <= RIAS_AL_CLEAR;
      fixed_q <= 1'b0;
    end
    else
    begin
      al_q <= al_d;
      fixed_q <= fixed_d;
    end
  end

  // forced stop state
  rias_fs_t fs_q;
  rias_fs_t fs_d;

  // forced stop next state; no fieldbus bit reaches here
  always_comb
  begin
    fs_d = fs_q;
    case (fs_q)
      RIAS_FS_RUN:
      begin
        if (!FORCED_STOP_INPUT)
        begin
          fs_d = RIAS_FS_STOP;
        end
      end
      RIAS_FS_STOP:
      begin
        if (FORCED_STOP_INPUT)
        begin
          fs_d = RIAS_FS_RUN;
        end
      end
      default:
      begin
        fs_d = RIAS_FS_STOP;
      end
    endcase
  end

  // register forced stop state
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      fs_q <= RIAS_FS_STOP;
    end
    else
    begin
      fs_q <= fs_d;
    end
  end

  // power stage outputs
  logic base_d;
  logic brake_d;
  logic alarm_d;
  logic fs_out_d;

  // power stage next values, from next states
  always_comb
  begin
    alarm_d = (al_d != RIAS_AL_CLEAR);
    fs_out_d = (fs_d != RIAS_FS_RUN);
    brake_d = fs_out_d || alarm_d;
    base_d = 1'b1;
    if (fs_out_d || alarm_d)
    begin
      base_d = 1'b0;
    end
    // shut-off on reset only when the parameter asks for it
    else if (reset_lvl && d1_shutoff)
    begin
      base_d = 1'b0;
    end
    // plain reset with no alarm leaves the base on
    else
    begin
      base_d = 1'b1;
    end
  end

  // register power stage outputs
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ALARM_ACTIVE <= 1'b0;
      BASE_ENABLE <= 1'b0;
      DYN_BRAKE <= 1'b1;
      FORCED_STOP_STATE <= 1'b1;
    end
    else
    begin
      ALARM_ACTIVE <= alarm_d;
      BASE_ENABLE <= base_d;
      DYN_BRAKE <= brake_d;
      FORCED_STOP_STATE <= fs_out_d;
    end
  end

  // select honoured gives incremental
  incr_honoured_a: assert property (
    @(posedge CLOCK) disable iff (!RESETN)
    (SPEC_SYSTEM_SELECT_BIT && COMMAND_SYSTEM_PARAM_ABS && ABS_INC_SELECT_BIT)
    |=> POS_INCREMENTAL)
    else $error("incremental select not honoured");

  // select ignored outside register absolute mode
  incr_ignored_a: assert property (
    @(posedge CLOCK) disable iff (!RESETN)
    !(SPEC_SYSTEM_SELECT_BIT && COMMAND_SYSTEM_PARAM_ABS)
    |=> !POS_INCREMENTAL)
    else $error("select bit acted outside its mode");

  // spec bit picks exactly one source
  spec_mode_a: assert property (
    @(posedge CLOCK) disable iff (!RESETN)
    SPEC_SYSTEM_SELECT_BIT |=> REGISTER_CMD_MODE && !POINT_TABLE_MODE)
    else $error("spec select not followed");

  // full hold clears a resettable alarm
  alarm_clear_a: assert property (
    @(posedge CLOCK) disable iff (!RESETN)
    (hold.done && !fixed_q && !ALARM_RAISE) |=> !ALARM_ACTIVE)
    else $error("resettable alarm not cleared");

  // fixed alarm survives a full hold
  alarm_fixed_a: assert property (
    @(posedge CLOCK) disable iff (!RESETN)
    (al_q == RIAS_AL_ACTIVE && fixed_q) |=> ALARM_ACTIVE && fixed_q)
    else $error("fixed alarm was cleared");

  // short reset pulse leaves an alarm standing
  alarm_short_a: assert property (
    @(posedge CLOCK) disable iff (!RESETN)
    (al_q == RIAS_AL_ACTIVE && !hold.done) |=> ALARM_ACTIVE)
    else $error("alarm cleared without a full hold");

  // reset without alarm keeps base on
  base_kept_a: assert property (
    @(posedge CLOCK) disable iff (!RESETN)
    (reset_lvl && !d1_shutoff && al_q == RIAS_AL_CLEAR && !ALARM_RAISE
      && fs_q == RIAS_FS_RUN && FORCED_STOP_INPUT) |=> BASE_ENABLE)
    else $error("base shut off by plain reset");

  // parameter shut-off on reset
  base_d1_off_a: assert property (
    @(posedge CLOCK) disable iff (!RESETN)
    (reset_lvl && d1_shutoff) |=> !BASE_ENABLE)
    else $error("base left on despite shut-off setting");

  // forced stop shuts base and brakes
  fs_enter_a: assert property (
    @(posedge CLOCK) disable iff (!RESETN)
    !FORCED_STOP_INPUT |=> FORCED_STOP_STATE && DYN_BRAKE && !BASE_ENABLE)
    else $error("forced stop not entered");

  // input back on leaves forced stop
  fs_leave_a: assert property (
    @(posedge CLOCK) disable iff (!RESETN)
    RESETN && fs_q == RIAS_FS_STOP && FORCED_STOP_INPUT |=> !FORCED_STOP_STATE)
    else $error("forced stop not left");

endmodule
